// [sctl_pkg.sv]
package sctl_pkg;
  // Timing
  localparam int SYS_PERIOD_NS = 50;
  localparam int LINK_PERIOD_NS = 400;
  localparam int SCK_HALF_CYCLES = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  // Frame geometry
  localparam logic [5:0] OPEN_BITS = 6'h20;
  localparam logic [5:0] LEGACY_BITS = 6'h1f;
  localparam logic [5:0] LEGACY_LOAD_AT = 6'h06;
  localparam logic [5:0] OPEN_FIRST_RD = 6'h01;
  localparam logic [5:0] LEGACY_FIRST_RD = 6'h08;
  localparam logic [5:0] READ_BITS = 6'h18;
  // Device register addresses
  localparam logic [4:0] ADDR_ID = 5'h00;
  localparam logic [4:0] ADDR_POWER = 5'h01;
  localparam logic [4:0] ADDR_VCO_ACCESS = 5'h05;
  localparam logic [4:0] ADDR_DRIVER = 5'h08;
  localparam logic [4:0] ADDR_CAL = 5'h0a;
  localparam logic [4:0] ADDR_PIN_CTRL = 5'h0f;
  localparam logic [3:0] VCO_ADDR_PERF = 4'h1;
  localparam logic [3:0] VCO_ADDR_PWR = 4'h2;
  // Field positions
  localparam int PWR_HONOUR_PIN = 0;
  localparam int PWR_SOFT_PD = 1;
  localparam int PWR_KEEP_LSB = 2;
  localparam int SOFT_RESET_BIT = 5;
  localparam int DRV_ENABLE_BIT = 5;
  localparam int CAL_OFF_BIT = 11;
  localparam int PIN_NO_AUTOMUX = 6;
  localparam int PIN_FORCE_ON = 7;
  localparam int PIN_NO_PULLUP = 8;
  localparam int PIN_NO_PULLDN = 9;
  localparam int VACC_ADDR_LSB = 3;
  localparam int VACC_DATA_LSB = 7;
  localparam int VCO_PERF_LSB = 2;
  localparam int VCO_DIV_ON = 8;
  localparam int VCO_PD_BIT = 3;
  // Reset values
  localparam logic [23:0] POWER_RESET = 24'h000001;
  localparam logic [23:0] DRIVER_RESET = 24'h000020;
  localparam logic [23:0] PIN_CTRL_RESET = 24'h000001;
  localparam logic [8:0] VCO_PERF_RESET = 9'h11c;
  localparam logic [8:0] VCO_PWR_RESET = 9'h000;
  // Host register byte offsets and command address bit positions
  localparam logic [4:0] HOST_CMD_DATA = 5'h00;
  localparam logic [4:0] HOST_CMD_ADDR = 5'h04;
  localparam logic [4:0] HOST_CONTROL = 5'h08;
  localparam logic [4:0] HOST_STATUS = 5'h0c;
  localparam logic [4:0] HOST_READ_DATA = 5'h10;
  localparam int CMD_CHIP_LSB = 5;
  localparam int CMD_LEGACY = 8;
  localparam int CMD_LEG_READ = 9;

  typedef enum logic [1:0] {PROTO_UNSET, PROTO_LEGACY, PROTO_OPEN} proto_t;

  function automatic logic [23:0] pll_reset_value(input logic [4:0] addr);
    case (addr)
      ADDR_POWER: return POWER_RESET;
      ADDR_DRIVER: return DRIVER_RESET;
      ADDR_PIN_CTRL: return PIN_CTRL_RESET;
      default: return 24'h000000;
    endcase
  endfunction
endpackage

// [serial_link_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface serial_link_if;
  logic sck;
  logic serial_frame_strobe;
  logic sdi;
  logic sdo_out;
  logic sdo_oe_n;
  wire logic sdo_line;

  // Pulled high when no one drives
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo_out;

  modport device (input sck, input serial_frame_strobe, input sdi, output sdo_out, output sdo_oe_n);
  modport host (output sck, output serial_frame_strobe, output sdi, input sdo_line);
endinterface
`default_nettype wire

// [pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw level in, synchronised level and edge pulses out
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] prev_reg;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          meta_reg[g] <= 1'b0;
          q_out[g] <= 1'b0;
          prev_reg[g] <= 1'b0;
        end
        else
        begin
          meta_reg[g] <= d_in[g];
          q_out[g] <= meta_reg[g];
          prev_reg[g] <= q_out[g];
        end
      end
      assign rise[g] = q_out[g] & ~prev_reg[g];
      assign fall[g] = ~q_out[g] & prev_reg[g];
    end
  endgenerate
endmodule // pin_sync
`default_nettype wire

// [synth_serial_host.sv]
`timescale 1ns/1ns
`default_nettype none
module synth_serial_host (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Serial link
  serial_link_if.host link
);
  typedef enum logic [2:0] {HS_IDLE, HS_LEAD, HS_BITS, HS_TAIL, HS_STROBE} host_state_t;

  host_state_t state_reg;
  logic [23:0] cmd_data_reg;
  logic [9:0] cmd_addr_reg;
  logic [23:0] rx_reg;
  logic [31:0] frame_reg;
  logic [5:0] bit_cnt_reg;
  logic [7:0] div_reg;
  logic sck_reg;
  logic sen_reg;
  logic sdi_reg;
  logic legacy_reg;
  logic sdo_s;

  pin_sync #(.WIDTH(1)) u_sdo_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d_in(link.sdo_line),
    .q_out(sdo_s),
    .rise(),
    .fall()
  );

  wire req = read | write;
  wire take = req & ~waitrequest;
  wire idle = state_reg == HS_IDLE;
  wire start = take & write & (address == sctl_pkg::HOST_CONTROL) & writedata[0] & idle;
  wire tick = div_reg == 8'(sctl_pkg::SCK_HALF_CYCLES - 1);
  wire legacy_sel = cmd_addr_reg[sctl_pkg::CMD_LEGACY];
  // Legacy: rw, pad, 5-bit address, data; open: data, address, chip
  wire [31:0] frame_word = legacy_sel ?
    {cmd_addr_reg[sctl_pkg::CMD_LEG_READ], 1'b0, cmd_addr_reg[4:0], cmd_data_reg, 1'b0} :
    {cmd_data_reg, cmd_addr_reg[4:0], cmd_addr_reg[7:5]};
  wire [5:0] nbits = legacy_reg ? sctl_pkg::LEGACY_BITS : sctl_pkg::OPEN_BITS;
  wire [5:0] first_rd = legacy_reg ? sctl_pkg::LEGACY_FIRST_RD : sctl_pkg::OPEN_FIRST_RD;
  wire [5:0] rise_num = bit_cnt_reg + 6'h01;
  wire in_window = (rise_num >= first_rd) && (rise_num < first_rd + sctl_pkg::READ_BITS);
  wire [31:0] rd_mux =
    (address == sctl_pkg::HOST_CMD_DATA) ? {8'h00, cmd_data_reg} :
    (address == sctl_pkg::HOST_CMD_ADDR) ? {22'h0, cmd_addr_reg} :
    (address == sctl_pkg::HOST_STATUS) ? {31'h0, ~idle} :
    (address == sctl_pkg::HOST_READ_DATA) ? {8'h00, rx_reg} : 32'h00000000;

  assign link.sck = sck_reg;
  assign link.serial_frame_strobe = sen_reg;
  assign link.sdi = sdi_reg;

  // Avalon slave: one wait cycle, answer at the second edge
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
      cmd_data_reg <= 24'h000000;
      cmd_addr_reg <= 10'h000;
    end
    else
    begin
      waitrequest <= ~(req & waitrequest);
      if (req & waitrequest)
        readdata <= rd_mux;
      if (take & write & (address == sctl_pkg::HOST_CMD_DATA))
        cmd_data_reg <= writedata[23:0];
      if (take & write & (address == sctl_pkg::HOST_CMD_ADDR))
        cmd_addr_reg <= writedata[9:0];
    end
  end

  // Frame engine, clocked by half-period ticks
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= HS_IDLE;
      div_reg <= 8'h00;
      sck_reg <= 1'b0;
      sen_reg <= 1'b0;
      sdi_reg <= 1'b0;
      legacy_reg <= 1'b0;
      bit_cnt_reg <= 6'h00;
      frame_reg <= 32'h00000000;
      rx_reg <= 24'h000000;
    end
    else
    begin
      div_reg <= (idle | tick) ? 8'h00 : div_reg + 8'h01;
      case (state_reg)
        HS_IDLE:
          if (start)
          begin
            state_reg <= HS_LEAD;
            legacy_reg <= legacy_sel;
            sen_reg <= legacy_sel;
            frame_reg <= frame_word;
            sdi_reg <= frame_word[31];
            bit_cnt_reg <= 6'h00;
          end
        HS_LEAD:
          if (tick)
            state_reg <= HS_BITS;
        HS_BITS:
          if (tick && !sck_reg)
          begin
            if (in_window)
              rx_reg <= {rx_reg[22:0], sdo_s};
            sck_reg <= 1'b1;
            bit_cnt_reg <= rise_num;
          end
          else if (tick)
          begin
            sck_reg <= 1'b0;
            frame_reg <= {frame_reg[30:0], 1'b0};
            sdi_reg <= frame_reg[30];
            if (bit_cnt_reg == nbits)
              state_reg <= HS_TAIL;
          end
        HS_TAIL:
          if (tick)
          begin
            sen_reg <= ~legacy_reg;
            state_reg <= legacy_reg ? HS_IDLE : HS_STROBE;
          end
        HS_STROBE:
          if (tick)
          begin
            sen_reg <= 1'b0;
            state_reg <= HS_IDLE;
          end
        default:
          state_reg <= HS_IDLE;
      endcase
    end
  end
endmodule // synth_serial_host
`default_nettype wire

// [synth_serial_device.sv]
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module synth_serial_device #(
  // Arbitrary identification value
  parameter logic [23:0] CHIP_ID = 24'h5a0c31
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial link
  serial_link_if.device link,
  // Pins and internal sources
  input wire logic chip_power_pin,
  input wire logic lock_indicator,
  input wire logic [31:0] test_signals,
  // Power and output controls
  output logic pll_enabled,
  output logic [5:0] block_keep_on,
  output logic vco_enabled,
  output logic main_rf_output_on,
  output logic divider_outputs_on,
  output logic [2:0] perf_level,
  output logic autocal_disable,
  output logic general_output_signal
);
  logic [23:0] pll_regs [32];
  logic [8:0] vco_perf_reg;
  logic [8:0] vco_pwr_reg;
  sctl_pkg::proto_t proto_reg;
  logic [31:0] shift_reg;
  logic [5:0] count_reg;
  logic addressed_reg;
  logic [23:0] rd_shift_reg;
  logic sdo_out_reg;
  logic sdo_oe_n_reg;
  logic [3:0] sync_q;
  logic [3:0] sync_rise;
  logic [3:0] sync_fall;

  pin_sync #(.WIDTH(4)) u_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d_in({chip_power_pin, link.sdi, link.serial_frame_strobe, link.sck}),
    .q_out(sync_q),
    .rise(sync_rise),
    .fall(sync_fall)
  );

  wire sck_rise = sync_rise[0];
  wire sen_s = sync_q[1];
  wire sen_rise = sync_rise[1];
  wire sen_fall = sync_fall[1];
  wire sdi_s = sync_q[2];
  wire cen_s = sync_q[3];

  // Protocol in force this cycle, including the deciding edge
  wire unset = proto_reg == sctl_pkg::PROTO_UNSET;
  wire mode_legacy = (proto_reg == sctl_pkg::PROTO_LEGACY) | (unset & sen_rise);
  wire mode_open = ~mode_legacy;

  wire [23:0] pwr = pll_regs[sctl_pkg::ADDR_POWER];
  wire [23:0] drv = pll_regs[sctl_pkg::ADDR_DRIVER];
  wire [23:0] cal = pll_regs[sctl_pkg::ADDR_CAL];
  wire [23:0] pin_ctrl = pll_regs[sctl_pkg::ADDR_PIN_CTRL];
  wire [4:0] read_addr = pll_regs[sctl_pkg::ADDR_ID][4:0];

  // Frame decode
  wire shift_en = sck_rise & (mode_open | sen_s);
  wire open_write = mode_open & sen_rise & (count_reg == sctl_pkg::OPEN_BITS)
    & (shift_reg[2:0] == 3'h0);
  wire leg_write = mode_legacy & sen_fall & (count_reg == sctl_pkg::LEGACY_BITS)
    & ~shift_reg[30];
  wire do_write = open_write | leg_write;
  // Only five of the six legacy address bits are kept
  wire [4:0] wr_addr = mode_legacy ? shift_reg[28:24] : shift_reg[7:3];
  wire [23:0] wr_data = mode_legacy ? shift_reg[23:0] : shift_reg[31:8];
  wire soft_reset = do_write & (wr_addr == sctl_pkg::ADDR_ID)
    & wr_data[sctl_pkg::SOFT_RESET_BIT];
  wire vco_write = do_write & (wr_addr == sctl_pkg::ADDR_VCO_ACCESS);
  wire [3:0] vco_addr = wr_data[sctl_pkg::VACC_ADDR_LSB +: 4];
  wire [8:0] vco_data = wr_data[sctl_pkg::VACC_DATA_LSB +: 9];

  // Read path
  wire leg_load = mode_legacy & shift_en & addressed_reg
    & (count_reg == sctl_pkg::LEGACY_LOAD_AT);
  wire open_load = mode_open & sen_fall;
  wire [4:0] rd_addr = leg_load ? {shift_reg[3:0], sdi_s} : read_addr;
  wire [23:0] rd_word = (rd_addr == sctl_pkg::ADDR_ID) ? CHIP_ID : pll_regs[rd_addr];
  wire rd_shift_en = shift_en & (mode_open | (count_reg > sctl_pkg::LEGACY_LOAD_AT));

  // Output pin selection and driver control
  wire [31:0] gpo_sources = {test_signals[31:2], lock_indicator, test_signals[0]};
  wire gpo_now = gpo_sources[pin_ctrl[4:0]];
  wire auto_read = addressed_reg & ~pin_ctrl[sctl_pkg::PIN_NO_AUTOMUX];
  wire sdo_data = auto_read ? rd_shift_reg[23] : gpo_now;
  wire want_drive = drv[sctl_pkg::DRV_ENABLE_BIT]
    & (pin_ctrl[sctl_pkg::PIN_FORCE_ON] | addressed_reg);
  wire half_ok = sdo_data ? ~pin_ctrl[sctl_pkg::PIN_NO_PULLUP]
    : ~pin_ctrl[sctl_pkg::PIN_NO_PULLDN];

  // Power decisions
  wire pll_pd = pwr[sctl_pkg::PWR_HONOUR_PIN] ? ~cen_s
    : pwr[sctl_pkg::PWR_SOFT_PD];
  wire vco_pd = vco_pwr_reg[sctl_pkg::VCO_PD_BIT];

  assign link.sdo_out = sdo_out_reg;
  assign link.sdo_oe_n = sdo_oe_n_reg;

  // PLL register file; soft reset leaves VCO and protocol alone
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || soft_reset)
    begin
      for (int i = 0; i < 32; i++)
        pll_regs[i] <= sctl_pkg::pll_reset_value(5'(i));
    end
    else if (do_write)
      pll_regs[wr_addr] <= wr_data;
  end

  // VCO registers, reachable only through the access register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      vco_perf_reg <= sctl_pkg::VCO_PERF_RESET;
      vco_pwr_reg <= sctl_pkg::VCO_PWR_RESET;
    end
    else if (vco_write && vco_addr == sctl_pkg::VCO_ADDR_PERF)
      vco_perf_reg <= vco_data;
    else if (vco_write && vco_addr == sctl_pkg::VCO_ADDR_PWR)
      vco_pwr_reg <= vco_data;
  end

  // Protocol lock, only released by power-on reset
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      proto_reg <= sctl_pkg::PROTO_UNSET;
    else if (unset && sen_rise)
      proto_reg <= sctl_pkg::PROTO_LEGACY;
    else if (unset && sck_rise)
      proto_reg <= sctl_pkg::PROTO_OPEN;
  end

  // Shifter and bit counter, independent of power-down
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      shift_reg <= 32'h00000000;
      count_reg <= 6'h00;
    end
    else
    begin
      if (shift_en)
        shift_reg <= {shift_reg[30:0], sdi_s};
      if ((mode_open && sen_fall) || (mode_legacy && sen_rise))
        count_reg <= 6'h00;
      else if (shift_en && count_reg != sctl_pkg::OPEN_BITS)
        count_reg <= count_reg + 6'h01;
    end
  end

  // Addressing and read-data shifter
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      addressed_reg <= 1'b0;
      rd_shift_reg <= 24'h000000;
    end
    else
    begin
      if (mode_open && sen_rise)
        addressed_reg <= (shift_reg[2:0] == 3'h0)
          | (count_reg < sctl_pkg::OPEN_BITS);
      else if (mode_legacy && shift_en && count_reg == 6'h00)
        addressed_reg <= sdi_s;
      else if (mode_legacy && sen_fall)
        addressed_reg <= 1'b0;
      if (leg_load || open_load)
        rd_shift_reg <= rd_word;
      else if (rd_shift_en)
        rd_shift_reg <= {rd_shift_reg[22:0], 1'b0};
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sdo_out_reg <= 1'b0;
      sdo_oe_n_reg <= 1'b1;
      pll_enabled <= 1'b0;
      block_keep_on <= 6'h00;
      vco_enabled <= 1'b0;
      main_rf_output_on <= 1'b0;
      divider_outputs_on <= 1'b0;
      perf_level <= 3'h0;
      autocal_disable <= 1'b0;
      general_output_signal <= 1'b0;
    end
    else
    begin
      sdo_out_reg <= sdo_data;
      sdo_oe_n_reg <= ~(want_drive & half_ok);
      pll_enabled <= ~pll_pd;
      block_keep_on <= {6{~pll_pd}} | pwr[sctl_pkg::PWR_KEEP_LSB +: 6];
      vco_enabled <= ~vco_pd;
      main_rf_output_on <= ~vco_pd;
      divider_outputs_on <= vco_perf_reg[sctl_pkg::VCO_DIV_ON] & ~vco_pd;
      perf_level <= vco_perf_reg[sctl_pkg::VCO_PERF_LSB +: 3];
      autocal_disable <= cal[sctl_pkg::CAL_OFF_BIT];
      general_output_signal <= gpo_now;
    end
  end
endmodule // synth_serial_device
`default_nettype wire

// [link_checker_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module link_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link wires
  input wire logic sck,
  input wire logic serial_frame_strobe,
  input wire logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe_n,
  input wire logic sdo_line
);
  logic sen_seen_reg;
  logic sck_reg;
  logic sen_reg;
  logic [5:0] rises_reg;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Strobe history and sck rises since the last strobe fall
  always_ff @(posedge sys_clk)
  begin
    sck_reg <= sck;
    sen_reg <= serial_frame_strobe;
    sen_seen_reg <= rst_n && (sen_seen_reg || serial_frame_strobe);
    rises_reg <= (!rst_n || (sen_reg && !serial_frame_strobe)) ? 6'h00 : rises_reg + {5'h00, sck && !sck_reg};
  end

  AST_RESET_QUIET: assert property (disable iff (1'b0) !rst_n |=> sdo_oe_n && !sck && !serial_frame_strobe && !sdi)
    else $error("link not idle after reset");
  AST_NO_DRIVE_BEFORE_STROBE: assert property (!sen_seen_reg |-> sdo_oe_n)
    else $error("output driven before any strobe");
  AST_SCK_HIGH_HOLD: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("sck high phase not four cycles");
  AST_SCK_LOW_HOLD: assert property ($fell(sck) |-> !sck [*4])
    else $error("sck low phase too short");
  AST_SDI_STEADY: assert property (sck && $past(sck) |-> $stable(sdi))
    else $error("sdi moved while sck high");
  AST_STROBE_RISE_SCK_LOW: assert property ($rose(serial_frame_strobe) |-> !sck)
    else $error("strobe rose with sck high");
  AST_STROBE_FALL_SCK_LOW: assert property ($fell(serial_frame_strobe) |-> !sck)
    else $error("strobe fell with sck high");
  AST_STROBE_RISE_COUNT: assert property ($rose(serial_frame_strobe) |-> rises_reg == 6'h20 || rises_reg == 6'h00)
    else $error("strobe rose after wrong rise count");
  AST_STROBE_WIDTH: assert property ($rose(serial_frame_strobe) |-> serial_frame_strobe [*4])
    else $error("strobe pulse too short");

  COV_OPEN_FRAME: cover property ($rose(serial_frame_strobe) && rises_reg == 6'h20);
  COV_LEGACY_FRAME: cover property ($rose(serial_frame_strobe) && rises_reg == 6'h00);
  COV_DRIVE_ON: cover property ($fell(sdo_oe_n));
  COV_DRIVE_LOW: cover property (!sdo_oe_n && !sdo_out && !sdo_line);
endmodule // link_checker
`default_nettype wire

// [test_power_down_and_sdo_output_control.sv]
`timescale 1ns/1ns
`default_nettype none
module test_power_down_and_sdo_output_control;
  // Arbitrary identification value
  localparam logic [23:0] ID_VAL = 24'h3c96a5;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic chip_power_pin = 1'b1;
  logic lock_indicator = 1'b0;
  logic [31:0] test_signals = 32'h0;
  logic pll_enabled, vco_enabled, main_rf_output_on, divider_outputs_on, autocal_disable, general_output_signal;
  logic [5:0] block_keep_on;
  logic [2:0] perf_level;
  logic [31:0] q;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;

  serial_link_if serial_link_if_i ();
  synth_serial_host synth_serial_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .link(serial_link_if_i.host));
  synth_serial_device #(.CHIP_ID(ID_VAL)) synth_serial_device_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .link(serial_link_if_i.device), .chip_power_pin(chip_power_pin), .lock_indicator(lock_indicator),
    .test_signals(test_signals), .pll_enabled(pll_enabled), .block_keep_on(block_keep_on),
    .vco_enabled(vco_enabled), .main_rf_output_on(main_rf_output_on), .divider_outputs_on(divider_outputs_on),
    .perf_level(perf_level), .autocal_disable(autocal_disable), .general_output_signal(general_output_signal));
  link_checker link_checker_i (.sys_clk(sys_clk), .rst_n(rst_n), .sck(serial_link_if_i.sck),
    .serial_frame_strobe(serial_link_if_i.serial_frame_strobe), .sdi(serial_link_if_i.sdi), .sdo_out(serial_link_if_i.sdo_out),
    .sdo_oe_n(serial_link_if_i.sdo_oe_n), .sdo_line(serial_link_if_i.sdo_line));

  always #25 sys_clk = ~sys_clk;

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      err_count++;
      close_out();
    end
  end

  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t value got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t level got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic settle;
    repeat (8) @(posedge sys_clk);
  endtask

  // One Avalon transfer, released at the edge that sees waitrequest low
  task automatic av(input logic [4:0] a, input logic wr, input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    do
      @(posedge sys_clk);
    while (waitrequest !== 1'b0);
    r = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic frame(input logic [2:0] c, input logic [4:0] rg, input logic [23:0] d, input logic leg,
    input logic lr);
    av(sctl_pkg::HOST_CMD_DATA, 1'b1, {8'h00, d}, q);
    av(sctl_pkg::HOST_CMD_ADDR, 1'b1, {22'h0, lr, leg, c, rg}, q);
    av(sctl_pkg::HOST_CONTROL, 1'b1, 32'h1, q);
    do
      av(sctl_pkg::HOST_STATUS, 1'b0, 32'h0, q);
    while (q[0] !== 1'b0);
    settle();
  endtask

  // Two-frame open read, then one legacy read
  task automatic oread(input logic [4:0] rg);
    frame(3'h0, sctl_pkg::ADDR_ID, {19'h0, rg}, 1'b0, 1'b0);
    frame(3'h0, sctl_pkg::ADDR_ID, {19'h0, rg}, 1'b0, 1'b0);
    av(sctl_pkg::HOST_READ_DATA, 1'b0, 32'h0, q);
  endtask

  task automatic lread(input logic [4:0] rg);
    frame(3'h0, rg, 24'h0, 1'b1, 1'b1);
    av(sctl_pkg::HOST_READ_DATA, 1'b0, 32'h0, q);
  endtask

  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk_bit(serial_link_if_i.sdo_oe_n, 1'b1);
    oread(sctl_pkg::ADDR_ID);
    chk_val(q[23:0], ID_VAL);
    oread(sctl_pkg::ADDR_POWER);
    chk_val(q[23:0], sctl_pkg::POWER_RESET);
    oread(sctl_pkg::ADDR_DRIVER);
    chk_val(q[23:0], sctl_pkg::DRIVER_RESET);
    oread(sctl_pkg::ADDR_PIN_CTRL);
    chk_val(q[23:0], sctl_pkg::PIN_CTRL_RESET);
    av(5'h14, 1'b0, 32'h0, q);
    chk_val(q[23:0], 24'h0);
    $display("test registers done");
    settle();
    chk_bit(pll_enabled, 1'b1);
    chip_power_pin <= 1'b0;
    settle();
    chk_bit(pll_enabled, 1'b0);
    chk_bit(vco_enabled, 1'b1);
    oread(sctl_pkg::ADDR_ID);
    chk_val(q[23:0], ID_VAL);
    frame(3'h0, sctl_pkg::ADDR_POWER, 24'h000000, 1'b0, 1'b0);
    chk_bit(pll_enabled, 1'b1);
    frame(3'h0, sctl_pkg::ADDR_POWER, 24'h0000b6, 1'b0, 1'b0);
    chk_bit(pll_enabled, 1'b0);
    chk_val(24'(block_keep_on), 24'h00002d);
    frame(3'h0, sctl_pkg::ADDR_POWER, sctl_pkg::POWER_RESET, 1'b0, 1'b0);
    chip_power_pin <= 1'b1;
    settle();
    chk_bit(pll_enabled, 1'b1);
    $display("test power done");
    chk_val(24'(perf_level), 24'h000007);
    frame(3'h0, sctl_pkg::ADDR_VCO_ACCESS, 24'h000008, 1'b0, 1'b0);
    chk_val(24'(perf_level), 24'h000000);
    chk_bit(divider_outputs_on, 1'b0);
    frame(3'h0, sctl_pkg::ADDR_VCO_ACCESS, 24'h008e08, 1'b0, 1'b0);
    chk_bit(divider_outputs_on, 1'b1);
    frame(3'h0, sctl_pkg::ADDR_VCO_ACCESS, 24'h000410, 1'b0, 1'b0);
    chk_bit(vco_enabled, 1'b0);
    chk_bit(main_rf_output_on, 1'b0);
    chk_bit(divider_outputs_on, 1'b0);
    frame(3'h0, sctl_pkg::ADDR_CAL, 24'h000800, 1'b0, 1'b0);
    chk_bit(autocal_disable, 1'b1);
    frame(3'h0, sctl_pkg::ADDR_ID, 24'h000020, 1'b0, 1'b0);
    chk_bit(autocal_disable, 1'b0);
    chk_bit(vco_enabled, 1'b0);
    frame(3'h0, sctl_pkg::ADDR_VCO_ACCESS, 24'h000010, 1'b0, 1'b0);
    chk_bit(main_rf_output_on, 1'b1);
    $display("test vco done");
    lock_indicator <= 1'b1;
    settle();
    chk_bit(general_output_signal, 1'b1);
    frame(3'h0, sctl_pkg::ADDR_PIN_CTRL, 24'h000003, 1'b0, 1'b0);
    chk_bit(serial_link_if_i.sdo_oe_n, 1'b0);
    test_signals <= 32'h8;
    settle();
    chk_bit(general_output_signal, 1'b1);
    test_signals <= 32'h0;
    settle();
    chk_bit(general_output_signal, 1'b0);
    frame(3'h3, sctl_pkg::ADDR_ID, 24'h0, 1'b0, 1'b0);
    chk_bit(serial_link_if_i.sdo_oe_n, 1'b1);
    frame(3'h0, sctl_pkg::ADDR_PIN_CTRL, 24'h000081, 1'b0, 1'b0);
    frame(3'h3, sctl_pkg::ADDR_ID, 24'h0, 1'b0, 1'b0);
    chk_bit(serial_link_if_i.sdo_oe_n, 1'b0);
    chk_bit(serial_link_if_i.sdo_line, 1'b1);
    lock_indicator <= 1'b0;
    settle();
    chk_bit(serial_link_if_i.sdo_line, 1'b0);
    frame(3'h0, sctl_pkg::ADDR_PIN_CTRL, 24'h0001c1, 1'b0, 1'b0);
    chk_bit(serial_link_if_i.sdo_oe_n, 1'b0);
    lock_indicator <= 1'b1;
    settle();
    chk_bit(serial_link_if_i.sdo_oe_n, 1'b1);
    frame(3'h0, sctl_pkg::ADDR_PIN_CTRL, 24'h0002c1, 1'b0, 1'b0);
    chk_bit(serial_link_if_i.sdo_oe_n, 1'b0);
    frame(3'h0, sctl_pkg::ADDR_DRIVER, 24'h000000, 1'b0, 1'b0);
    chk_bit(serial_link_if_i.sdo_oe_n, 1'b1);
    frame(3'h0, sctl_pkg::ADDR_DRIVER, sctl_pkg::DRIVER_RESET, 1'b0, 1'b0);
    frame(3'h0, sctl_pkg::ADDR_PIN_CTRL, 24'h0000c1, 1'b0, 1'b0);
    oread(sctl_pkg::ADDR_ID);
    chk_val(q[23:0], 24'hffffff);
    $display("test output pin done");
    settle();
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk_bit(serial_link_if_i.sdo_oe_n, 1'b1);
    frame(3'h0, sctl_pkg::ADDR_CAL, 24'h000800, 1'b1, 1'b0);
    chk_bit(autocal_disable, 1'b1);
    lread(sctl_pkg::ADDR_ID);
    chk_val(q[23:0], ID_VAL);
    frame(3'h0, sctl_pkg::ADDR_ID, 24'h000020, 1'b1, 1'b0);
    chk_bit(autocal_disable, 1'b0);
    lread(sctl_pkg::ADDR_ID);
    chk_val(q[23:0], ID_VAL);
    frame(3'h0, sctl_pkg::ADDR_CAL, 24'h000800, 1'b0, 1'b0);
    chk_bit(autocal_disable, 1'b0);
    $display("test legacy done");
    close_out();
  end
endmodule // test_power_down_and_sdo_output_control
`default_nettype wire
